// ==== hw/gpio_p1p3.v ====
// Port 1 bidirectional and port 3 fixed-function I/O control.
// Assumes one 40 MHz clock, async active-high reset, Avalon-MM
// slave with waitrequest, comparator cells and timers outside.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_p1p3_defs.vh"
module gpio_p1p3 (
  input wire CLOCK,
  input wire RST,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output wire IRQ,
  input wire [7:0] P1_IN,
  output reg [7:0] P1_OUT,
  output reg [7:0] P1_OE_N,
  input wire [3:0] P3_IN,
  output reg [7:4] P3_OUT,
  input wire P20_IN,
  input wire COMPARATOR_A_RAW,
  input wire COMPARATOR_B_RAW,
  output reg COMPARATOR_PWRDN,
  input wire STOP_MODE,
  input wire STOP_RECOVER,
  input wire EIGHT_BIT_TIMER,
  input wire SIXTEEN_BIT_TIMER,
  input wire COMBINED_TIMER,
  input wire ANDOR_OUT,
  output reg TIMER_EDGE_IN,
  output reg INTR_REQ_ZERO,
  output reg INTR_REQ_ONE,
  output reg INTR_REQ_TWO
);

  // ****************************************
  // Synchronizers
  // ****************************************
  wire [7:0] p1_sync;
  wire [3:0] p3_sync;
  wire [2:0] misc_sync;

  sync2 #(.W(8)) u_sync_p1 (
    .CLOCK(CLOCK),
    .RST(RST),
    .D(P1_IN),
    .Q(p1_sync)
  );

  sync2 #(.W(4)) u_sync_p3 (
    .CLOCK(CLOCK),
    .RST(RST),
    .D(P3_IN),
    .Q(p3_sync)
  );

  sync2 #(.W(3)) u_sync_misc (
    .CLOCK(CLOCK),
    .RST(RST),
    .D({P20_IN, COMPARATOR_B_RAW, COMPARATOR_A_RAW}),
    .Q(misc_sync)
  );

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] p1_data_r;
  reg [7:0] p1_dir_r;
  reg [7:0] port_config_reg;
  reg [7:0] p3_mode_r;
  reg [7:4] p3_data_r;
  reg [7:0] irq_edge_r;
  reg [7:0] timer_ctl_zero;
  reg [7:0] timer_ctl_one;
  reg [7:0] timer_ctl_two;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_stat_nxt;
  reg [2:0] irq_mask_r;
  reg edge_src_r;

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait cycle per request gives time to register read data,
  // so read data stand from flops at the accepting edge.
  reg ack_r;
  wire req = AVS_READ | AVS_WRITE;
  wire accept = req & ack_r;
  // Only byte lane 0 carries a register; other lanes are ignored
  wire wr_en = AVS_WRITE & accept & AVS_BYTEENABLE[0];
  wire rd_stat = AVS_READ & accept & (AVS_ADDRESS == `OFS_IRQ_STAT);
  wire [7:0] wbyte = AVS_WRITEDATA[7:0];

  assign AVS_WAITREQUEST = req & ~ack_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************
  // Comparators
  // ****************************************
  wire analog_en = p3_mode_r[`MODE_ANALOG];
  // Results forced low while stopped, so nothing sees a stale edge
  wire cmp_a = misc_sync[0] & analog_en & ~STOP_MODE;
  wire cmp_b = misc_sync[1] & analog_en & ~STOP_MODE;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      COMPARATOR_PWRDN <= `RST_PWRDN;
    end else begin
      COMPARATOR_PWRDN <= ~analog_en | STOP_MODE;
    end
  end

  // Levels seen on bits 1 and 2: comparator or digital pin
  wire lvl1 = analog_en ? cmp_a : p3_sync[1];
  wire lvl2 = analog_en ? cmp_b : p3_sync[2];
  wire [3:0] p3_view = {p3_sync[3], lvl2, lvl1, p3_sync[0]};

  // ****************************************
  // Edge detection and interrupt requests
  // ****************************************
  reg [3:1] prev_r;
  wire [1:0] edge_sel = irq_edge_r[`EDGE_SEL_HI:`EDGE_SEL_LO];
  wire rise1 = lvl1 & ~prev_r[1];
  wire fall1 = ~lvl1 & prev_r[1];
  wire rise2 = lvl2 & ~prev_r[2];
  wire fall2 = ~lvl2 & prev_r[2];
  wire fall3 = ~p3_sync[3] & prev_r[3];
  reg ev1;
  reg ev2;
  // Switching the level source (pin to comparator, or comparator shut
  // off by stop mode) moves lvl1/lvl2 with no pin edge; that cycle is
  // masked so software sees no spurious interrupt.
  reg [1:0] src_q_r;
  wire [1:0] src_now = {STOP_MODE, analog_en};
  wire src_moved = |(src_now ^ src_q_r);

  // One selector serves both bits; they cannot be set apart
  always @* begin
    case (edge_sel)
      `EDGE_FALL: begin
        ev1 = fall1;
        ev2 = fall2;
      end
      `EDGE_RISE: begin
        ev1 = rise1;
        ev2 = rise2;
      end
      default: begin
        ev1 = rise1 | fall1;
        ev2 = rise2 | fall2;
      end
    endcase
    if (src_moved) begin
      ev1 = 1'b0;
      ev2 = 1'b0;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Status bit n belongs to request n
  wire [2:0] events = {ev1, fall3, ev2};

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (rd_stat) begin
      // Clear only what the pending read returned; new events win
      irq_stat_nxt = irq_stat_nxt & ~AVS_READDATA[2:0];
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prev_r <= 3'h0;
      INTR_REQ_ZERO <= 1'b0;
      INTR_REQ_ONE <= 1'b0;
      INTR_REQ_TWO <= 1'b0;
      irq_stat_r <= `RST_IRQ;
      src_q_r <= 2'b00;
    end else begin
      prev_r <= p3_view[3:1];
      src_q_r <= src_now;
      INTR_REQ_ZERO <= ev2;
      INTR_REQ_ONE <= fall3;
      INTR_REQ_TWO <= ev1;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      p1_data_r <= `RST_BYTE;
      p1_dir_r <= `RST_P1_DIR;
      port_config_reg <= `RST_PORT_CFG;
      p3_mode_r <= `RST_BYTE;
      p3_data_r <= 4'h0;
      irq_edge_r <= `RST_BYTE;
      timer_ctl_zero <= `RST_BYTE;
      timer_ctl_one <= `RST_BYTE;
      timer_ctl_two <= `RST_BYTE;
      irq_mask_r <= `RST_IRQ;
      edge_src_r <= 1'b0;
    end else begin
      // Writes land only at the accepting edge
      if (wr_en) begin
        case (AVS_ADDRESS)
          `OFS_P1_DATA: p1_data_r <= wbyte;
          `OFS_P1_DIR: p1_dir_r <= wbyte;
          `OFS_PORT_CFG: port_config_reg <= wbyte;
          `OFS_P3_MODE: p3_mode_r <= wbyte;
          `OFS_P3_DATA: p3_data_r <= wbyte[7:4];
          `OFS_IRQ_EDGE: irq_edge_r <= wbyte;
          `OFS_TCTL0: timer_ctl_zero <= wbyte;
          `OFS_TCTL1: timer_ctl_one <= wbyte;
          `OFS_TCTL2: timer_ctl_two <= wbyte;
          `OFS_IRQ_MASK: irq_mask_r <= wbyte[2:0];
          `OFS_EDGE_SRC: edge_src_r <= wbyte[`EDGE_SRC_P20];
          default: ;
        endcase
      end
      // Recovery overrides a same-cycle direction write
      if (STOP_RECOVER) begin
        p1_dir_r <= `RST_P1_DIR;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  reg [7:0] rd_mux;
  // Unmapped offsets read as zero

  always @* begin
    case (AVS_ADDRESS)
      `OFS_P1_DATA: rd_mux = p1_data_r;
      `OFS_P1_DIR: rd_mux = p1_dir_r;
      `OFS_P1_PINS: rd_mux = p1_sync;
      `OFS_PORT_CFG: rd_mux = port_config_reg;
      `OFS_P3_MODE: rd_mux = p3_mode_r;
      `OFS_P3_DATA: rd_mux = {p3_data_r, 4'h0};
      `OFS_P3_PINS: rd_mux = {P3_OUT, p3_view};
      `OFS_IRQ_EDGE: rd_mux = irq_edge_r;
      `OFS_TCTL0: rd_mux = timer_ctl_zero;
      `OFS_TCTL1: rd_mux = timer_ctl_one;
      `OFS_TCTL2: rd_mux = timer_ctl_two;
      `OFS_IRQ_STAT: rd_mux = {5'h00, irq_stat_r};
      `OFS_IRQ_MASK: rd_mux = {5'h00, irq_mask_r};
      `OFS_EDGE_SRC: rd_mux = {7'h00, edge_src_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // Captured on the wait cycle, presented at the accepting edge
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & ~ack_r) begin
      AVS_READDATA <= {24'h00_0000, rd_mux};
    end
  end

  // ****************************************
  // Port 1 pins
  // ****************************************
  wire p1_pp = port_config_reg[`CFG_P1_PP];
  // Open-drain drives only a low; a 1 lets the pin float high
  wire [7:0] p1_drive = p1_dir_r & (p1_pp ? 8'hff : ~p1_data_r);
  // Data and enable reach the pins one cycle after the registers

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      P1_OUT <= 8'h00;
      P1_OE_N <= `RST_P1_OE_N;
    end else begin
      P1_OUT <= p1_data_r;
      P1_OE_N <= ~p1_drive;
    end
  end

  // ****************************************
  // Port 3 outputs
  // ****************************************
  wire cmp_route = port_config_reg[`CFG_CMP_OUT];
  wire [1:0] p36_sel = timer_ctl_one[`TCTL1_SEL_HI:`TCTL1_SEL_LO];
  reg p36_nxt;

  always @* begin
    case (p36_sel)
      `P36_COMBINED: p36_nxt = COMBINED_TIMER;
      `P36_ANDOR: p36_nxt = ANDOR_OUT;
      default: p36_nxt = p3_data_r[6];
    endcase
  end

  // Comparator routing wins over timer and latch on bits 4 and 7
  wire p34_nxt = cmp_route ? cmp_a :
    (timer_ctl_zero[`TCTL0_P34_TMR] ? EIGHT_BIT_TIMER : p3_data_r[4]);
  wire p35_nxt = timer_ctl_two[`TCTL2_P35_TMR] ? SIXTEEN_BIT_TIMER :
    p3_data_r[5];
  wire p37_nxt = cmp_route ? cmp_b : p3_data_r[7];

  // Bits 7..4 are always driven; there is no direction control
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      P3_OUT <= 4'h0;
    end else begin
      P3_OUT <= {p37_nxt, p36_nxt, p35_nxt, p34_nxt};
    end
  end

  // ****************************************
  // Timer edge input
  // ****************************************
  // Registered so the timer sees one clean level per cycle
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      TIMER_EDGE_IN <= 1'b0;
    end else begin
      TIMER_EDGE_IN <= edge_src_r ? misc_sync[2] : lvl1;
    end
  end

endmodule // gpio_p1p3
`default_nettype wire

// ==== include/gpio_p1p3_defs.vh ====
// Register offsets, field positions, reset values and encodings
// for the port 1 / port 3 control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word each.
`ifndef GPIO_P1P3_DEFS_VH
`define GPIO_P1P3_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_P1_DATA 6'h00
`define OFS_P1_DIR 6'h04
`define OFS_P1_PINS 6'h08
`define OFS_PORT_CFG 6'h0c
`define OFS_P3_MODE 6'h10
`define OFS_P3_DATA 6'h14
`define OFS_P3_PINS 6'h18
`define OFS_IRQ_EDGE 6'h1c
`define OFS_TCTL0 6'h20
`define OFS_TCTL1 6'h24
`define OFS_TCTL2 6'h28
`define OFS_IRQ_STAT 6'h2c
`define OFS_IRQ_MASK 6'h30
`define OFS_EDGE_SRC 6'h34

// ****************************************
// Field positions
// ****************************************
`define CFG_CMP_OUT 0
`define CFG_P1_PP 1
`define MODE_ANALOG 1
`define EDGE_SEL_LO 6
`define EDGE_SEL_HI 7
`define TCTL0_P34_TMR 0
`define TCTL1_SEL_LO 4
`define TCTL1_SEL_HI 5
`define TCTL2_P35_TMR 0
`define EDGE_SRC_P20 0

// ****************************************
// Reset values
// ****************************************
`define RST_P1_DIR 8'h00
`define RST_PORT_CFG 8'h00
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0
`define RST_P1_OE_N 8'hff
`define RST_PWRDN 1'b1

// ****************************************
// Encodings
// ****************************************
// Edge select, bits 7:6 of the interrupt edge register
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
// Port 3 bit 6 source, timer control one bits 5:4
`define P36_LATCH 2'h0
`define P36_COMBINED 2'h1
`define P36_ANDOR 2'h2

`endif

// ==== hw/sync2.v ====
// Two-flop synchronizer for a bus of independent level inputs.
// Assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input wire CLOCK,
  input wire RST,
  input wire [W-1:0] D,
  output reg [W-1:0] Q
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meta_r <= {W{1'b0}};
      Q <= {W{1'b0}};
    end else begin
      meta_r <= D;
      Q <= meta_r;
    end
  end
endmodule // sync2
`default_nettype wire

// ==== tb/gpio_p1p3_chk.sv ====
// Concurrent checks on the ports of the port 1 / port 3 control block.
// Assumes it is bound to gpio_p1p3 and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module gpio_p1p3_chk (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ,
  input wire logic [7:0] P1_OE_N,
  input wire logic [3:0] P3_IN,
  input wire logic COMPARATOR_PWRDN,
  input wire logic STOP_MODE,
  input wire logic STOP_RECOVER,
  input wire logic INTR_REQ_ONE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ****************************************
  // Sequences
  // ****************************************
  sequence one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  sequence stat_read;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h2c;
  endsequence
  rd_wait_a: assert property ($rose(AVS_READ) |-> one_wait)
    else $error("read not answered after one wait cycle");
  wr_wait_a: assert property ($rose(AVS_WRITE) |-> one_wait)
    else $error("write not answered after one wait cycle");
  rd_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST
    |-> AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  oe_reset_a: assert property ($fell(RST) |-> P1_OE_N == 8'hff)
    else $error("port 1 driving right after reset");
  oe_recover_a: assert property (STOP_RECOVER |-> ##2 P1_OE_N == 8'hff)
    else $error("port 1 not input after recovery");
  cmp_stop_a: assert property (STOP_MODE |=> COMPARATOR_PWRDN)
    else $error("comparators powered in stop mode");
  irq_fall_a: assert property ($fell(P3_IN[3]) |-> ##[2:6] INTR_REQ_ONE)
    else $error("no request one after falling edge");
  irq_clear_a: assert property (stat_read |-> ##[1:2] !IRQ)
    else $error("interrupt still high after status read");
endmodule // gpio_p1p3_chk

bind gpio_p1p3 gpio_p1p3_chk u_gpio_p1p3_chk (.CLOCK(CLOCK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ), .P1_OE_N(P1_OE_N), .P3_IN(P3_IN),
  .COMPARATOR_PWRDN(COMPARATOR_PWRDN), .STOP_MODE(STOP_MODE),
  .STOP_RECOVER(STOP_RECOVER), .INTR_REQ_ONE(INTR_REQ_ONE));
`default_nettype wire

// ==== tb/board_model.sv ====
// Board side of port 1: resolves each pin from the block and the board.
// Assumes the board level stands wherever the block does not drive.
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p1_ext,
  output logic [7:0] p1_pin
);
  // A released bit shows the board level, never the stale block value
  assign p1_pin = (p1_oe_n & p1_ext) | (~p1_oe_n & p1_out);
endmodule // board_model
`default_nettype wire

// ==== tb/gpio_p1p3_tb.sv ====
// Self-checking bench for the port 1 / port 3 control block.
// Assumes the design, its header, board model and checker compile first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpio_p1p3_tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0, wrq, irq, pwrdn, tedge;
  logic [5:0] addr = 0;
  logic [3:0] be = 4'hf, p3_in = 0, tmr = 0;
  logic [31:0] wdata = 0, rdata, ev;
  logic [7:0] p1_out, p1_oe_n, p1_pin, p1_ext = 0, r, d, e;
  logic [7:4] p3_out;
  logic p20 = 0, cmp_a = 0, cmp_b = 0, stop = 0, recover = 0, i0, i1, i2;
  integer seed = 32'hcda0d1e3;
  int failures = 0, checks_done = 0;
  integer cnt0 = 0, cnt1 = 0, cnt2 = 0;
  logic [31:0] expq[$];
  always #12.5 clk = ~clk;
  gpio_p1p3 u_gpio_p1p3 (.CLOCK(clk), .RST(rst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wrq),
    .IRQ(irq), .P1_IN(p1_pin), .P1_OUT(p1_out), .P1_OE_N(p1_oe_n),
    .P3_IN(p3_in), .P3_OUT(p3_out), .P20_IN(p20), .COMPARATOR_A_RAW(cmp_a),
    .COMPARATOR_B_RAW(cmp_b), .COMPARATOR_PWRDN(pwrdn), .STOP_MODE(stop),
    .STOP_RECOVER(recover), .EIGHT_BIT_TIMER(tmr[0]),
    .SIXTEEN_BIT_TIMER(tmr[1]), .COMBINED_TIMER(tmr[2]), .ANDOR_OUT(tmr[3]),
    .TIMER_EDGE_IN(tedge), .INTR_REQ_ZERO(i0), .INTR_REQ_ONE(i1),
    .INTR_REQ_TWO(i2));
  board_model u_board_model (.p1_out(p1_out), .p1_oe_n(p1_oe_n),
    .p1_ext(p1_ext), .p1_pin(p1_pin));
  // ****************************************
  // Tasks and watchers
  // ****************************************
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Waitrequest is sampled at the rising edge, as the slave sees it
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, v};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 16);
    if (wrq !== 1'b0) begin
      failures++;
      end_of_test();
    end
    rd <= 0;
    wr <= 0;
  endtask
  task automatic chk_rd(input logic [5:0] a, input logic [31:0] x);
    expq.push_back(x);
    bus(0, a, 8'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (rd === 1'b1 && wrq === 1'b0) begin
      ev = expq.pop_front();
      `CHK(rdata, ev)
    end
  end
  always @(posedge clk) begin
    cnt0 <= cnt0 + i0;
    cnt1 <= cnt1 + i1;
    cnt2 <= cnt2 + i2;
  end
  initial begin
    #500000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    wt(1);
    `CHK(p1_oe_n, 8'hff)
    chk_rd(6'h04, 32'h0);
    $display("Test reset done");
    bus(1, 6'h30, 8'h07);
    for (int m = 0; m < 4; m++) begin
      bus(1, 6'h1c, {m[1:0], 6'h0});
      wt(1);
      cnt0 = 0;
      cnt1 = 0;
      cnt2 = 0;
      @(posedge clk) p3_in <= 4'he;
      wt(8);
      @(posedge clk) p3_in <= 4'h0;
      wt(8);
      `CHK(cnt2, (m >= 2) ? 2 : 1)
      `CHK(cnt0, (m >= 2) ? 2 : 1)
      `CHK(cnt1, 1)
      `CHK(irq, 1'b1)
      chk_rd(6'h2c, 32'h7);
      wt(2);
      `CHK(irq, 1'b0)
    end
    bus(1, 6'h30, 8'h00);
    @(posedge clk) p3_in <= 4'h8;
    wt(8);
    @(posedge clk) p3_in <= 4'h0;
    wt(8);
    `CHK(irq, 1'b0)
    bus(1, 6'h30, 8'h02);
    wt(2);
    `CHK(irq, 1'b1)
    chk_rd(6'h2c, 32'h2);
    $display("Test interrupts done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      r = 8'($random(seed));
      @(posedge clk) p1_ext <= r;
      bus(1, 6'h00, d);
      bus(1, 6'h04, 8'h3c);
      bus(1, 6'h0c, {6'h0, i[0], 1'b0});
      wt(3);
      e = i[0] ? 8'h3c : (8'h3c & ~d);
      `CHK(p1_oe_n, ~e)
      `CHK(p1_out, d)
      chk_rd(6'h08, {24'h0, (~e & r) | (e & d)});
    end
    $display("Test port 1 done");
    @(posedge clk) tmr <= 4'($random(seed));
    @(posedge clk) p3_in <= 4'h9;
    bus(1, 6'h14, 8'ha0);
    wt(4);
    `CHK(p3_out, 4'ha)
    chk_rd(6'h18, 32'ha9);
    bus(1, 6'h20, 8'h01);
    bus(1, 6'h28, 8'h01);
    bus(1, 6'h24, 8'h10);
    wt(2);
    `CHK(p3_out, {1'b1, tmr[2], tmr[1], tmr[0]})
    bus(1, 6'h24, 8'h20);
    wt(2);
    `CHK(p3_out[6], tmr[3])
    @(posedge clk) p3_in <= 4'hb;
    wt(5);
    `CHK(tedge, 1'b1)
    bus(1, 6'h34, 8'h01);
    wt(5);
    `CHK(tedge, 1'b0)
    @(posedge clk) p20 <= 1;
    wt(5);
    `CHK(tedge, 1'b1)
    $display("Test port 3 done");
    @(posedge clk) cmp_a <= 1;
    @(posedge clk) cmp_b <= 1;
    bus(1, 6'h0c, 8'h01);
    bus(1, 6'h10, 8'h02);
    wt(5);
    `CHK({p3_out[7], p3_out[4], pwrdn}, 3'b110)
    @(posedge clk) stop <= 1;
    wt(4);
    `CHK({p3_out[7], p3_out[4], pwrdn}, 3'b001)
    @(posedge clk) stop <= 0;
    bus(1, 6'h10, 8'h00);
    @(posedge clk) recover <= 1;
    @(posedge clk) recover <= 0;
    wt(2);
    `CHK(p1_oe_n, 8'hff)
    chk_rd(6'h04, 32'h0);
    $display("Test stop mode done");
    chk_rd(6'h3c, 32'h0);
    @(posedge clk) be <= 4'h0;
    bus(1, 6'h04, 8'hff);
    @(posedge clk) be <= 4'hf;
    chk_rd(6'h04, 32'h0);
    $display("Test bus refusals done");
    end_of_test();
  end
endmodule // gpio_p1p3_tb
`default_nettype wire
